// ### pkg/smc_pkg.sv
/*
 * Constants and types for the sleep mode controller: mode codes, clock
 * gate bit positions, wake-source bit positions and wake-up timing counts.
 * Assumes a single 20 MHz system clock; times are turned into cycles here.
 */
// How it works
// - Sleep starts only with sleep_enable set and a SLEEP; mode field picks mode.
// - Interrupt wake-up stalls the core four cycles beyond clock start-up.
// - Sleep never touches register file or SRAM contents.
// - Any reset during sleep wakes the part and restarts at the reset vector.
// - Brown-out sleep disable turns the detector off at entry, back on at wake.
// - After detector was off, wake-up is stretched to about 60 us.
// - Brown-out sleep disable resets to 0, detector active in sleep.
// - The disable bit changes only inside a timed enable sequence.
// - Detector disable applies only in power-down, save, standby, ext standby; code also applies it for mode codes 100 and 101.
// - Idle (000) stops cpu and flash clocks; any enabled interrupt wakes.
// - Idle or noise reduction entry starts an ADC conversion if ADC enabled.
// - Noise reduction (001) stops io, cpu, flash; ADC, async, touch run.
// - Noise reduction wakes only from its listed sources.
// - In noise reduction the timer wakes only when run asynchronously.
// - Power-down (010) stops oscillator and all generated clocks.
// - A level wake source must hold its level until start-up ends.
// - Power-down wake waits the fuse-chosen reset time-out before resuming.
// - Outside idle the external pins wake only when level-sensitive.
// - A serial port wakes the part only by start-frame detection.
// - Power-save keeps main clock running when touch controller is enabled.
// - Power-save (011) is power-down plus running async timer wake.
// - Standby 110 and ext standby 111 keep oscillator; resume in six cycles.
package smc_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int BOD_WAKE_NS = 60_000;
    localparam int BOD_WAKE_CYC = (BOD_WAKE_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int STALL_CYC = 4;
    localparam int STANDBY_CYC = 6;
    localparam int TIMED_WIN_CYC = 4;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;
    localparam logic [2:0] MODE_XSTBY = 3'h7;
    localparam logic BROWNOUT_SLEEP_DISABLE_RESET = 1'b0;
    // clock gate vector bits: 1 means the domain runs
    localparam int CK_CPU = 0;
    localparam int CK_FLASH = 1;
    localparam int CK_IO = 2;
    localparam int CK_ADC = 3;
    localparam int CK_ASY = 4;
    localparam int CK_TOUCH = 5;
    localparam int CK_MAIN = 6;
    localparam int CK_TOSC = 7;
    localparam int CK_W = 8;
    // wake source bits
    localparam int WK_EXT_LEVEL = 0;
    localparam int WK_EXT_EDGE = 1;
    localparam int WK_PIN_CHANGE = 2;
    localparam int WK_TWI_MATCH = 3;
    localparam int WK_TIMER2 = 4;
    localparam int WK_SPM_EE = 5;
    localparam int WK_ADC = 6;
    localparam int WK_WDT = 7;
    localparam int WK_USART_SF = 8;
    localparam int WK_OTHER_IO = 9;
    localparam int WK_W = 10;
    typedef enum logic [2:0] {
        SMC_RUN = 3'b000,
        SMC_SLEEP = 3'b001,
        SMC_START = 3'b010,
        SMC_STALL = 3'b011,
        SMC_RESET = 3'b100
    } smc_state_e;
endpackage : smc_pkg

// ### pkg/smc_cnt_if.sv
/*
 * Interface between the sleep controller and its wake-up delay counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface smc_cnt_if;
    logic load;
    logic [15:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport cnt (input load, input count, output done);
endinterface : smc_cnt_if

// ### rtl/smc_delay.sv
/*
 * Down counter for the wake-up delays. Loaded with a cycle count, it
 * raises done once the count has elapsed. Same clock as the controller.
 */
`timescale 1ns/100ps
module smc_delay (
    input wire logic clk,
    input wire logic rst,
    smc_cnt_if.cnt cif
);
    logic [15:0] cnt_r;
    logic run_r;

    // count down, done while the count stands at one
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            run_r <= 1'b0;
        end else if (cif.load) begin
            cnt_r <= cif.count;
            run_r <= 1'b1;
        end else if (run_r && cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end else begin
            run_r <= 1'b0;
        end
    end

    assign cif.done = run_r && (cnt_r == 16'h0001);
endmodule : smc_delay

// ### rtl/smc_ctrl.sv
/*
 * Sleep mode controller top. Takes the SLEEP strobe from the core, gates
 * the clock domains for the chosen mode, filters wake sources and times
 * the wake-up. Assumes wake sources are already synchronous to clk and
 * that system resets arrive on sys_reset_req as a level.
 */
`timescale 1ns/100ps
module smc_ctrl #(
    parameter int STARTUP_CYC = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_enable,
    input wire logic [2:0] mode_select_field,
    input wire logic sleep_instr,
    input wire logic brownout_sleep_disable_enable_wr,
    input wire logic brownout_sleep_disable_wr,
    input wire logic brownout_sleep_disable_wdata,
    input wire logic adc_enabled,
    input wire logic touch_enabled,
    input wire logic timer2_async,
    input wire logic [2:0] ext_int_level_sense,
    input wire logic [2:0] ext_int_req,
    input wire logic [smc_pkg::WK_W-1:0] wake_req,
    input wire logic sys_reset_req,
    output logic [smc_pkg::CK_W-1:0] clk_run,
    output logic core_stall,
    output logic wake_irq,
    output logic wake_reset,
    output logic adc_start,
    output logic brownout_detector_on,
    output logic brownout_sleep_disable,
    output logic sleeping
);
    smc_pkg::smc_state_e state_r, state_nxt;
    logic [2:0] mode_r;
    logic bod_off_r;
    logic by_reset_r;
    logic [2:0] win_r;
    logic wake_hit;
    logic [smc_pkg::WK_W-1:0] wake_mask;
    logic [15:0] start_cyc;
    smc_cnt_if cif();

    smc_delay u_delay (
        .clk(clk),
        .rst(rst),
        .cif(cif)
    );

    // clocks running in each mode; power-save keeps main clock for touch
    function automatic logic [smc_pkg::CK_W-1:0] gate_of(
        input logic [2:0] m, input logic touch, input logic asy);
        logic [smc_pkg::CK_W-1:0] g;
        g = '0;
        unique case (m)
            // timer oscillator only runs when the timer is asynchronous
            smc_pkg::MODE_IDLE: g = {asy, 7'h7C};
            smc_pkg::MODE_ADCNR: g = {asy, 7'h78};
            smc_pkg::MODE_PDOWN: g = 8'h00;
            smc_pkg::MODE_PSAVE: g = {asy, touch, 1'b1, asy, 4'h0};
            smc_pkg::MODE_STBY: g = 8'h40;
            smc_pkg::MODE_XSTBY: g = {asy, 1'b1, 1'b1, asy, 4'h0};
            default: g = 8'h00;
        endcase
        return g;
    endfunction : gate_of

    // sources allowed to wake in each mode
    always_comb begin
        wake_mask = '0;
        unique case (mode_r)
            smc_pkg::MODE_IDLE: wake_mask = '1;
            smc_pkg::MODE_ADCNR: begin
                wake_mask[smc_pkg::WK_EXT_LEVEL] = 1'b1;
                wake_mask[smc_pkg::WK_PIN_CHANGE] = 1'b1;
                wake_mask[smc_pkg::WK_TWI_MATCH] = 1'b1;
                wake_mask[smc_pkg::WK_TIMER2] = timer2_async;
                wake_mask[smc_pkg::WK_SPM_EE] = 1'b1;
                wake_mask[smc_pkg::WK_ADC] = 1'b1;
                wake_mask[smc_pkg::WK_WDT] = 1'b1;
                wake_mask[smc_pkg::WK_USART_SF] = 1'b1;
            end
            default: begin
                wake_mask[smc_pkg::WK_EXT_LEVEL] = 1'b1;
                wake_mask[smc_pkg::WK_PIN_CHANGE] = 1'b1;
                wake_mask[smc_pkg::WK_TWI_MATCH] = 1'b1;
                wake_mask[smc_pkg::WK_WDT] = 1'b1;
                wake_mask[smc_pkg::WK_USART_SF] = 1'b1;
                wake_mask[smc_pkg::WK_TIMER2] =
                    (mode_r == smc_pkg::MODE_PSAVE) ||
                    (mode_r == smc_pkg::MODE_XSTBY);
            end
        endcase
    end

    // edge-set pins wake only from idle; usart via start frame
    assign wake_hit = |(wake_req & wake_mask) ||
        (|(ext_int_req & ext_int_level_sense)) ||
        ((mode_r == smc_pkg::MODE_IDLE) && |ext_int_req);

    // start-up length by mode and detector state
    always_comb begin
        if (bod_off_r) begin
            start_cyc = 16'(smc_pkg::BOD_WAKE_CYC);
        end else if (mode_r == smc_pkg::MODE_STBY ||
                     mode_r == smc_pkg::MODE_XSTBY) begin
            start_cyc = 16'(smc_pkg::STANDBY_CYC);
        end else if (mode_r == smc_pkg::MODE_IDLE ||
                     mode_r == smc_pkg::MODE_ADCNR) begin
            start_cyc = 16'h0001;
        end else begin
            start_cyc = 16'(STARTUP_CYC);
        end
    end

    // next state of the sleep sequence
    always_comb begin
        state_nxt = state_r;
        cif.load = 1'b0;
        cif.count = start_cyc;
        unique case (state_r)
            smc_pkg::SMC_RUN: begin
                if (sleep_instr && sleep_enable) begin
                    state_nxt = smc_pkg::SMC_SLEEP;
                end
            end
            smc_pkg::SMC_SLEEP: begin
                if (sys_reset_req) begin
                    state_nxt = smc_pkg::SMC_RESET;
                end else if (wake_hit) begin
                    state_nxt = smc_pkg::SMC_START;
                    cif.load = 1'b1;
                end
            end
            smc_pkg::SMC_START: begin
                if (cif.done) begin
                    state_nxt = smc_pkg::SMC_STALL;
                    cif.load = 1'b1;
                    cif.count = 16'(smc_pkg::STALL_CYC);
                end
            end
            smc_pkg::SMC_STALL: begin
                if (cif.done) begin
                    state_nxt = smc_pkg::SMC_RUN;
                end
            end
            smc_pkg::SMC_RESET: begin
                if (!sys_reset_req) begin
                    state_nxt = smc_pkg::SMC_RUN;
                end
            end
            default: state_nxt = smc_pkg::SMC_RUN;
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= smc_pkg::SMC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // latch mode at entry so a later field write cannot change gating
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= smc_pkg::MODE_IDLE;
        end else if (state_r == smc_pkg::SMC_RUN && sleep_instr &&
                     sleep_enable) begin
            mode_r <= mode_select_field;
        end
    end

    // timed window opened by the enable write
    always_ff @(posedge clk) begin
        if (rst) begin
            win_r <= 3'h0;
        end else if (brownout_sleep_disable_enable_wr) begin
            win_r <= 3'(smc_pkg::TIMED_WIN_CYC);
        end else if (win_r != 3'h0) begin
            win_r <= win_r - 3'h1;
        end
    end

    // disable bit, resets to zero, written only in window
    always_ff @(posedge clk) begin
        if (rst) begin
            brownout_sleep_disable <= smc_pkg::BROWNOUT_SLEEP_DISABLE_RESET;
        end else if (brownout_sleep_disable_wr && win_r != 3'h0 && !brownout_sleep_disable_enable_wr) begin
            brownout_sleep_disable <= brownout_sleep_disable_wdata;
        end
    end

    // detector off at entry in deep modes, on again at wake
    always_ff @(posedge clk) begin
        if (rst) begin
            bod_off_r <= 1'b0;
        end else if (state_r == smc_pkg::SMC_RUN && sleep_instr &&
                     sleep_enable) begin
            bod_off_r <= brownout_sleep_disable &&
                mode_select_field != smc_pkg::MODE_IDLE &&
                mode_select_field != smc_pkg::MODE_ADCNR;
        end else if (state_r != smc_pkg::SMC_SLEEP) begin
            // back on one cycle after the wake edge so it settles before code runs
            bod_off_r <= 1'b0;
        end
    end

    // remember whether the wake came from a reset
    always_ff @(posedge clk) begin
        if (rst) begin
            by_reset_r <= 1'b0;
        end else begin
            by_reset_r <= (state_nxt == smc_pkg::SMC_RESET);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_run <= '1;
        end else if (state_nxt == smc_pkg::SMC_SLEEP) begin
            // at entry mode_r is not yet loaded, so use the live field
            clk_run <= gate_of(state_r == smc_pkg::SMC_RUN ?
                mode_select_field : mode_r, touch_enabled, timer2_async);
        end else begin
            clk_run <= '1;
        end
    end

    // one-cycle ADC start at entry to idle or noise reduction
    always_ff @(posedge clk) begin
        if (rst) begin
            adc_start <= 1'b0;
        end else begin
            adc_start <= state_r == smc_pkg::SMC_RUN && sleep_instr &&
                sleep_enable && adc_enabled &&
                (mode_select_field == smc_pkg::MODE_IDLE ||
                 mode_select_field == smc_pkg::MODE_ADCNR);
        end
    end

    // irq only if wake source still present in the last stall cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= state_r == smc_pkg::SMC_STALL && cif.done &&
                wake_hit;
        end
    end

    // no memory control here: storage keeps its clock-free contents
    assign core_stall = state_r != smc_pkg::SMC_RUN;
    assign sleeping = state_r == smc_pkg::SMC_SLEEP;
    assign wake_reset = by_reset_r;
    assign brownout_detector_on = !bod_off_r;

    // no gating after a disabled SLEEP
    a_noop_sleep: assert property (@(posedge clk) disable iff (rst)
        state_r == smc_pkg::SMC_RUN && sleep_instr && !sleep_enable
        |=> state_r == smc_pkg::SMC_RUN)
        else $error("sleep entered with enable clear");
    a_stall_len: assert property (@(posedge clk) disable iff (rst)
        $rose(state_r == smc_pkg::SMC_STALL)
        |-> (state_r == smc_pkg::SMC_STALL)[*4] ##1
            state_r == smc_pkg::SMC_RUN)
        else $error("stall not four cycles");
    a_reset_wake: assert property (@(posedge clk) disable iff (rst)
        state_r == smc_pkg::SMC_SLEEP && sys_reset_req
        |=> state_r == smc_pkg::SMC_RESET && wake_reset)
        else $error("reset did not wake");
    a_bod_shallow: assert property (@(posedge clk) disable iff (rst)
        sleeping && (mode_r == smc_pkg::MODE_IDLE ||
                     mode_r == smc_pkg::MODE_ADCNR)
        |-> brownout_detector_on)
        else $error("detector off in shallow mode");
    a_brownout_sleep_disable_guard: assert property (@(posedge clk) disable iff (rst)
        win_r == 3'h0 |=> $stable(brownout_sleep_disable))
        else $error("disable bit written outside window");
    a_idle_gate: assert property (@(posedge clk) disable iff (rst)
        sleeping && $past(sleeping) && mode_r == smc_pkg::MODE_IDLE
        |-> !clk_run[smc_pkg::CK_CPU] && clk_run[smc_pkg::CK_IO])
        else $error("idle gating wrong");
    a_stby_time: assert property (@(posedge clk) disable iff (rst)
        sleeping && wake_hit && !sys_reset_req && !bod_off_r &&
        mode_r == smc_pkg::MODE_STBY
        |=> (state_r == smc_pkg::SMC_START)[*6] ##1
            state_r == smc_pkg::SMC_STALL)
        else $error("standby wake not six cycles");
    a_pdown_gate: assert property (@(posedge clk) disable iff (rst)
        sleeping && $past(sleeping) && mode_r == smc_pkg::MODE_PDOWN
        |-> clk_run == '0)
        else $error("power-down clocks running");
endmodule : smc_ctrl

// ### dv/smc_core_model.sv
/*
 * Model of the core and of the wake sources that face the controller.
 * Assumes the controller's clock and its synchronous active-high reset.
 */
`timescale 1ns/100ps
module smc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_cmd,
    input wire logic [smc_pkg::WK_W-1:0] wake_cmd,
    input wire logic core_stall,
    output logic sleep_instr,
    output logic [smc_pkg::WK_W-1:0] wake_req
);
    // core issues sleep
    // a stalled core executes nothing, so it cannot issue a sleep strobe
    assign sleep_instr = sleep_cmd & ~core_stall;

    // level held through start-up
    // a source keeps its request until the core runs again
    always_ff @(posedge clk) begin
        if (rst || !core_stall) begin
            wake_req <= '0;
        end else begin
            wake_req <= wake_req | wake_cmd;
        end
    end
endmodule : smc_core_model

// ### dv/smc_ctrl_test.sv
/*
 * Self-checking bench for the sleep mode controller with its core model.
 * Assumes a 50 ns clock, inputs moved 2 ns after each rising edge.
 */
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module smc_ctrl_test;
    localparam int SU = 4;
    logic clk, rst, sleep_enable, sleep_cmd, sleep_instr;
    logic brownout_sleep_disable_enable_wr, brownout_sleep_disable_wr, brownout_sleep_disable_wdata;
    logic adc_enabled, touch_enabled, timer2_async, sys_reset_req;
    logic [2:0] mode_select_field, ext_int_level_sense, ext_int_req;
    logic [smc_pkg::WK_W-1:0] wake_cmd, wake_req;
    logic [smc_pkg::CK_W-1:0] clk_run;
    logic core_stall, wake_irq, wake_reset, adc_start, sleeping;
    logic brownout_detector_on, brownout_sleep_disable, adc_seen;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    smc_ctrl #(.STARTUP_CYC(SU)) smc_ctrl_i (.clk(clk), .rst(rst),
        .sleep_enable(sleep_enable), .mode_select_field(mode_select_field),
        .sleep_instr(sleep_instr), .brownout_sleep_disable_enable_wr(brownout_sleep_disable_enable_wr),
        .brownout_sleep_disable_wr(brownout_sleep_disable_wr), .brownout_sleep_disable_wdata(brownout_sleep_disable_wdata),
        .adc_enabled(adc_enabled), .touch_enabled(touch_enabled),
        .timer2_async(timer2_async),
        .ext_int_level_sense(ext_int_level_sense),
        .ext_int_req(ext_int_req), .wake_req(wake_req),
        .sys_reset_req(sys_reset_req), .clk_run(clk_run),
        .core_stall(core_stall), .wake_irq(wake_irq),
        .wake_reset(wake_reset), .adc_start(adc_start),
        .brownout_detector_on(brownout_detector_on),
        .brownout_sleep_disable(brownout_sleep_disable),
        .sleeping(sleeping));
    smc_core_model smc_core_model_i (.clk(clk), .rst(rst),
        .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd),
        .core_stall(core_stall), .sleep_instr(sleep_instr),
        .wake_req(wake_req));

    // free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard: the whole run needs well under 5000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // one sleep strobe; adc_seen records an entry conversion start
    task automatic enter(input logic [2:0] m, input logic se);
        mode_select_field = m;
        sleep_enable = se;
        sleep_cmd = 1'b1;
        tick(1);
        sleep_cmd = 1'b0;
        // the entry pulse stands only in the cycle right after the strobe
        adc_seen = adc_start;
        repeat (3) begin
            tick(1);
            adc_seen |= adc_start;
        end
    endtask : enter

    // raise one source and time the stall while it is held
    task automatic wake(input int b, input int n_exp);
        int n;
        logic irq;
        n = 0;
        irq = 1'b0;
        wake_cmd[b] = 1'b1;
        tick(1);
        wake_cmd = '0;
        for (int i = 0; i < 3000 && core_stall; i++) begin
            if (wake_req[b]) n++;
            irq |= wake_irq;
            tick(1);
        end
        irq |= wake_irq;
        tick(1);
        irq |= wake_irq;
        `CHK("stall_len", n_exp, n)
        `CHK("wake_irq", 1'b1, irq)
        `CHK("clk_run_back", 8'hFF, clk_run)
    endtask : wake

    // a source that must not end the sleep
    task automatic ignore(input int b);
        wake_cmd[b] = 1'b1;
        tick(1);
        wake_cmd = '0;
        tick(20);
        `CHK("still_asleep", 1'b1, sleeping)
    endtask : ignore

    task automatic t_nop();
        enter(smc_pkg::MODE_PDOWN, 1'b0);
        `CHK("nop_sleeping", 1'b0, sleeping)
        `CHK("nop_clk_run", 8'hFF, clk_run)
        $display("test nop done");
    endtask : t_nop

    task automatic t_idle();
        adc_enabled = 1'b1;
        timer2_async = 1'b1;
        enter(smc_pkg::MODE_IDLE, 1'b1);
        `CHK("idle_sleeping", 1'b1, sleeping)
        `CHK("idle_clk_run", 8'hFC, clk_run)
        `CHK("idle_adc_start", 1'b1, adc_seen)
        wake(smc_pkg::WK_OTHER_IO, 1 + smc_pkg::STALL_CYC + 1);
        $display("test idle done");
    endtask : t_idle

    task automatic t_adcnr();
        timer2_async = 1'b0;
        enter(smc_pkg::MODE_ADCNR, 1'b1);
        `CHK("nr_clk_run", 8'h78, clk_run)
        `CHK("nr_adc_start", 1'b1, adc_seen)
        ignore(smc_pkg::WK_OTHER_IO);
        ignore(smc_pkg::WK_TIMER2);
        ignore(smc_pkg::WK_EXT_EDGE);
        wake(smc_pkg::WK_ADC, 1 + smc_pkg::STALL_CYC + 1);
        adc_enabled = 1'b0;
        $display("test noise reduction done");
    endtask : t_adcnr

    task automatic t_pdown();
        enter(smc_pkg::MODE_PDOWN, 1'b1);
        `CHK("pd_clk_run", 8'h00, clk_run)
        `CHK("pd_adc_start", 1'b0, adc_seen)
        ignore(smc_pkg::WK_TIMER2);
        ignore(smc_pkg::WK_SPM_EE);
        ignore(smc_pkg::WK_USART_SF - 2);
        ext_int_req = 3'h1;
        tick(20);
        `CHK("pd_edge_pin", 1'b1, sleeping)
        ext_int_req = 3'h0;
        wake(smc_pkg::WK_PIN_CHANGE, SU + smc_pkg::STALL_CYC + 1);
        ext_int_level_sense = 3'h4;
        enter(smc_pkg::MODE_PDOWN, 1'b1);
        ext_int_req = 3'h4;
        tick(SU + 12);
        `CHK("pd_level_pin", 1'b0, core_stall)
        ext_int_req = 3'h0;
        enter(smc_pkg::MODE_PDOWN, 1'b1);
        wake(smc_pkg::WK_USART_SF, SU + smc_pkg::STALL_CYC + 1);
        $display("test power-down done");
    endtask : t_pdown

    task automatic t_save_stby();
        touch_enabled = 1'b1;
        enter(smc_pkg::MODE_PSAVE, 1'b1);
        `CHK("ps_main_osc", 1'b1, clk_run[smc_pkg::CK_MAIN])
        wake(smc_pkg::WK_TIMER2, SU + smc_pkg::STALL_CYC + 1);
        touch_enabled = 1'b0;
        enter(smc_pkg::MODE_PSAVE, 1'b1);
        `CHK("ps_main_off", 1'b0, clk_run[smc_pkg::CK_MAIN])
        wake(smc_pkg::WK_TWI_MATCH, SU + smc_pkg::STALL_CYC + 1);
        enter(smc_pkg::MODE_STBY, 1'b1);
        `CHK("sb_main_osc", 1'b1, clk_run[smc_pkg::CK_MAIN])
        wake(smc_pkg::WK_WDT, smc_pkg::STANDBY_CYC + 5);
        enter(smc_pkg::MODE_XSTBY, 1'b1);
        wake(smc_pkg::WK_PIN_CHANGE, smc_pkg::STANDBY_CYC + 5);
        $display("test save and standby done");
    endtask : t_save_stby

    task automatic t_brownout_sleep_disable();
        brownout_sleep_disable_wdata = 1'b1;
        brownout_sleep_disable_wr = 1'b1;
        tick(1);
        brownout_sleep_disable_enable_wr = 1'b1;
        tick(1);
        brownout_sleep_disable_wr = 1'b0;
        brownout_sleep_disable_enable_wr = 1'b0;
        tick(6);
        `CHK("brownout_sleep_disable_guard", 1'b0, brownout_sleep_disable)
        brownout_sleep_disable_enable_wr = 1'b1;
        tick(1);
        brownout_sleep_disable_enable_wr = 1'b0;
        tick(2);
        brownout_sleep_disable_wr = 1'b1;
        tick(1);
        brownout_sleep_disable_wr = 1'b0;
        tick(1);
        `CHK("brownout_sleep_disable_set", 1'b1, brownout_sleep_disable)
        enter(smc_pkg::MODE_IDLE, 1'b1);
        `CHK("bod_idle_on", 1'b1, brownout_detector_on)
        wake(smc_pkg::WK_OTHER_IO, 1 + smc_pkg::STALL_CYC + 1);
        enter(smc_pkg::MODE_PDOWN, 1'b1);
        `CHK("bod_off", 1'b0, brownout_detector_on)
        wake(smc_pkg::WK_PIN_CHANGE, smc_pkg::BOD_WAKE_CYC + 5);
        `CHK("bod_back_on", 1'b1, brownout_detector_on)
        $display("test brown-out done");
    endtask : t_brownout_sleep_disable

    task automatic t_reset();
        logic seen;
        seen = 1'b0;
        enter(smc_pkg::MODE_PDOWN, 1'b1);
        sys_reset_req = 1'b1;
        repeat (4) begin
            tick(1);
            seen |= wake_reset;
        end
        sys_reset_req = 1'b0;
        for (int i = 0; i < 100 && core_stall; i++) tick(1);
        `CHK("rst_wake", 1'b1, seen)
        `CHK("rst_no_irq", 1'b0, wake_irq)
        `CHK("rst_running", 1'b0, core_stall)
        $display("test reset wake done");
    endtask : t_reset

    // main sequence: reset for 12 cycles, then each scenario in turn
    initial begin
        rst = 1'b1;
        {sleep_enable, sleep_cmd, brownout_sleep_disable_enable_wr, brownout_sleep_disable_wr} = 4'h0;
        {brownout_sleep_disable_wdata, adc_enabled, touch_enabled, timer2_async} = 4'h0;
        sys_reset_req = 1'b0;
        mode_select_field = 3'h0;
        ext_int_level_sense = 3'h0;
        ext_int_req = 3'h0;
        wake_cmd = '0;
        tick(12);
        rst = 1'b0;
        tick(1);
        `CHK("rst_clk_run", 8'hFF, clk_run)
        `CHK("rst_brownout_sleep_disable", smc_pkg::BROWNOUT_SLEEP_DISABLE_RESET, brownout_sleep_disable)
        `CHK("rst_bod_on", 1'b1, brownout_detector_on)
        t_nop();
        t_idle();
        t_adcnr();
        t_pdown();
        t_save_stby();
        t_brownout_sleep_disable();
        t_reset();
        test_done();
    end
endmodule : smc_ctrl_test
